// ### hdl/port_xbar_regs.vh
// constants shared by the port pin cells and the priority crossbar
//
// Contract
// - after reset every cell is digital, high-impedance, with weak pull-up on
// - analog input kind turns off that pin's pull-up and digital receiver
// - an analog pin reads back as 0 whatever the pad level
// - push-pull style drives the pad high or low following the output value
// - open-drain style pulls low for 0 and releases both drivers for 1
// - pull-up only while high-impedance; off when driven or globally disabled
// - a digital pin reads the actual pad level, not the driven value
// - per-pin high or low drive strength, low by default after reset
// - edge events on any digital pin, bypassed or claimed, never on analog
// - crossbar uses pins P0.0 to P1.6; a set bypass bit skips a pin, except the fixed uart and second serial pins
// - uart has top priority and is routed to P0.4 and P0.5
// - second serial peripheral next, fixed on P1.0 to P1.3
// - other functions take lowest free pins in fixed priority order
// - all output drivers stay off while the crossbar is disabled
// - two-wire bus pins are forced to open-drain when that function is selected
// - first serial slave select gets a pin only in 4-wire mode, shifting the rest
// - port write latches output value; read returns pins, latch kept for rmw
`ifndef PORT_XBAR_REGS_VH
`define PORT_XBAR_REGS_VH

// ==========================================================
// sizes
`define N_PIN 16
`define N_XBAR 15
`define N_FN 26
`define FN_W 5

// ==========================================================
// crossbar function signals, in priority order
`define FN_UART_TX 0
`define FN_UART_RX 1
`define FN_SECOND_SERIAL_PERIPH_FIRST 2
`define FN_SECOND_SERIAL_PERIPH_CNT 4
`define FN_DYN_FIRST 6
`define FN_FIRST_SERIAL_PERIPH_SCK 6
`define FN_FIRST_SERIAL_PERIPH_MISO 7
`define FN_FIRST_SERIAL_PERIPH_MOSI 8
`define FN_FIRST_SERIAL_PERIPH_SS 9
`define FN_SMB_SDA 10
`define FN_SMB_SCL 11
`define FN_CP0 12
`define FN_CP0A 13
`define FN_CP1 14
`define FN_CP1A 15
`define FN_SYSCLK 16
`define FN_CEX0 17
`define FN_CEX_MAX 6
`define FN_ECI 23
`define FN_T0 24
`define FN_T1 25

// ==========================================================
// fixed pins
`define PIN_UART_TX 4
`define PIN_UART_RX 5
`define PIN_SECOND_SERIAL_PERIPH_FIRST 8

// ==========================================================
// function select bit positions
`define SEL0_UART 0
`define SEL0_FIRST_SERIAL_PERIPH 1
`define SEL0_SMB 2
`define SEL0_SYSCLK 3
`define SEL0_CP0 4
`define SEL0_CP0A 5
`define SEL0_CP1 6
`define SEL0_CP1A 7
`define SEL1_PCA_LSB 0
`define SEL1_PCA_MSB 2
`define SEL1_ECI 3
`define SEL1_T0 4
`define SEL1_T1 5
`define SEL2_SECOND_SERIAL_PERIPH 0
`define SS_MODE_3WIRE 2'h0

// ==========================================================
// reset values
`define LATCH_RST 16'hffff
`define PIN_LVL_RST 16'hffff

`endif

// ### hdl/port_xbar.v
// general-purpose pin cells with priority crossbar and edge event capture
`timescale 1ns/100ps
`include "port_xbar_regs.vh"

module port_xbar #(
  parameter N_PIN = `N_PIN,
  parameter N_XBAR = `N_XBAR,
  parameter N_FN = `N_FN,
  parameter FN_W = `FN_W
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin configuration
  input wire [N_XBAR-1:0] pin_input_kind_select,
  input wire [N_PIN-1:0] pin_output_style_select,
  input wire [N_XBAR-1:0] crossbar_bypass_bits,
  input wire [N_PIN-1:0] pin_drive_strength_select,
  input wire pullup_global_disable,
  // crossbar configuration
  input wire crossbar_enable,
  input wire [7:0] function_select_0,
  input wire [7:0] function_select_1,
  input wire [7:0] function_select_2,
  input wire [1:0] slave_select_mode_bits,
  // port data access
  input wire [N_PIN-1:0] port_wr_mask,
  input wire [N_PIN-1:0] port_wr_data,
  output wire [N_PIN-1:0] port_rd_pins,
  output wire [N_PIN-1:0] port_rd_latch,
  // peripheral function signals
  input wire [N_FN-1:0] fn_out,
  input wire [N_FN-1:0] fn_oe,
  output wire [N_FN-1:0] fn_in,
  // status and events
  output wire [N_XBAR-1:0] pin_claimed,
  output wire [N_PIN-1:0] pin_event,
  // pads
  input wire [N_PIN-1:0] pad_in,
  output wire [N_PIN-1:0] pad_out,
  output wire [N_PIN-1:0] pad_oe,
  output wire [N_PIN-1:0] pad_pullup_en,
  output wire [N_PIN-1:0] pad_drive_high,
  output wire [N_PIN-1:0] pad_analog
);

  // ==========================================================
  // port latch
  reg [N_PIN-1:0] latch_r;
  wire [N_PIN-1:0] latch_nxt;

  // only masked bits change so that bit-wise writes leave the rest intact
  assign latch_nxt = (latch_r & ~port_wr_mask) | (port_wr_data & port_wr_mask);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // rmw instructions take the latch, plain reads the pins
  assign port_rd_latch = latch_r;

  // ==========================================================
  // function requests
  reg [N_FN-1:0] fn_req;
  wire [2:0] pca_cnt;
  integer k;

  assign pca_cnt = function_select_1[`SEL1_PCA_MSB:`SEL1_PCA_LSB];

  always @* begin
    fn_req = {N_FN{1'b0}};
    fn_req[`FN_UART_TX] = function_select_0[`SEL0_UART];
    fn_req[`FN_UART_RX] = function_select_0[`SEL0_UART];
    for (k = 0; k < `FN_SECOND_SERIAL_PERIPH_CNT; k = k + 1) begin
      fn_req[`FN_SECOND_SERIAL_PERIPH_FIRST + k] = function_select_2[`SEL2_SECOND_SERIAL_PERIPH];
    end
    fn_req[`FN_FIRST_SERIAL_PERIPH_SCK] = function_select_0[`SEL0_FIRST_SERIAL_PERIPH];
    fn_req[`FN_FIRST_SERIAL_PERIPH_MISO] = function_select_0[`SEL0_FIRST_SERIAL_PERIPH];
    fn_req[`FN_FIRST_SERIAL_PERIPH_MOSI] = function_select_0[`SEL0_FIRST_SERIAL_PERIPH];
    // 3-wire mode leaves the select line off the pins
    fn_req[`FN_FIRST_SERIAL_PERIPH_SS] = function_select_0[`SEL0_FIRST_SERIAL_PERIPH] &
                          (slave_select_mode_bits != `SS_MODE_3WIRE);
    fn_req[`FN_SMB_SDA] = function_select_0[`SEL0_SMB];
    fn_req[`FN_SMB_SCL] = function_select_0[`SEL0_SMB];
    fn_req[`FN_CP0] = function_select_0[`SEL0_CP0];
    fn_req[`FN_CP0A] = function_select_0[`SEL0_CP0A];
    fn_req[`FN_CP1] = function_select_0[`SEL0_CP1];
    fn_req[`FN_CP1A] = function_select_0[`SEL0_CP1A];
    fn_req[`FN_SYSCLK] = function_select_0[`SEL0_SYSCLK];
    for (k = 0; k < `FN_CEX_MAX; k = k + 1) begin
      fn_req[`FN_CEX0 + k] = (k < pca_cnt);
    end
    fn_req[`FN_ECI] = function_select_1[`SEL1_ECI];
    fn_req[`FN_T0] = function_select_1[`SEL1_T0];
    fn_req[`FN_T1] = function_select_1[`SEL1_T1];
  end

  // ==========================================================
  // priority assignment
  // purely combinational: any settings change re-routes on the next edge
  reg [N_XBAR-1:0] asg_valid;
  reg [N_XBAR*FN_W-1:0] asg_idx;
  reg [N_XBAR-1:0] taken;
  reg found;
  integer f;
  integer p;
  integer fi;

  always @* begin
    fi = 0;
    asg_valid = {N_XBAR{1'b0}};
    asg_idx = {N_XBAR*FN_W{1'b0}};
    taken = crossbar_bypass_bits;
    found = 1'b0;
    if (fn_req[`FN_UART_TX]) begin
      asg_valid[`PIN_UART_TX] = 1'b1;
      fi = `FN_UART_TX;
      asg_idx[`PIN_UART_TX*FN_W +: FN_W] = fi[FN_W-1:0];
      asg_valid[`PIN_UART_RX] = 1'b1;
      fi = `FN_UART_RX;
      asg_idx[`PIN_UART_RX*FN_W +: FN_W] = fi[FN_W-1:0];
      taken[`PIN_UART_TX] = 1'b1;
      taken[`PIN_UART_RX] = 1'b1;
    end
    for (f = 0; f < `FN_SECOND_SERIAL_PERIPH_CNT; f = f + 1) begin
      if (fn_req[`FN_SECOND_SERIAL_PERIPH_FIRST + f]) begin
        asg_valid[`PIN_SECOND_SERIAL_PERIPH_FIRST + f] = 1'b1;
        fi = f + `FN_SECOND_SERIAL_PERIPH_FIRST;
        asg_idx[(`PIN_SECOND_SERIAL_PERIPH_FIRST + f)*FN_W +: FN_W] = fi[FN_W-1:0];
        taken[`PIN_SECOND_SERIAL_PERIPH_FIRST + f] = 1'b1;
      end
    end
    // lowest free pin per function; bypassed and claimed pins are skipped
    for (f = `FN_DYN_FIRST; f < N_FN; f = f + 1) begin
      found = 1'b0;
      if (fn_req[f]) begin
        for (p = 0; p < N_XBAR; p = p + 1) begin
          if (!found && !taken[p]) begin
            taken[p] = 1'b1;
            asg_valid[p] = 1'b1;
            asg_idx[p*FN_W +: FN_W] = f[FN_W-1:0];
            found = 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // per-pin cells
  wire [N_PIN-1:0] dig;
  wire [N_PIN-1:0] fsel;
  wire [N_PIN*FN_W-1:0] pin_fidx;
  wire [N_PIN-1:0] rx_lvl;
  reg [N_PIN-1:0] out_r;
  reg [N_PIN-1:0] oe_r;
  reg [N_PIN-1:0] pu_r;
  reg [N_PIN-1:0] drv_r;
  reg [N_PIN-1:0] ana_r;
  reg [N_PIN-1:0] lvl_r;
  reg [N_PIN-1:0] lvl_prev_r;
  reg [N_PIN-1:0] dig_prev_r;
  reg [N_PIN-1:0] evt_r;

  genvar g;
  generate
    for (g = 0; g < N_PIN; g = g + 1) begin : g_pin
      wire [FN_W-1:0] idx;
      wire val;
      wire want_drv;
      wire od;
      wire oe_nxt;
      wire out_nxt;
      wire pu_nxt;

      if (g < N_XBAR) begin : g_xb
        assign dig[g] = pin_input_kind_select[g];
        assign fsel[g] = asg_valid[g];
        assign pin_fidx[g*FN_W +: FN_W] = asg_idx[g*FN_W +: FN_W];
      end else begin : g_fixed
        // the last pin is digital only and outside the crossbar
        assign dig[g] = 1'b1;
        assign fsel[g] = 1'b0;
        assign pin_fidx[g*FN_W +: FN_W] = {FN_W{1'b0}};
      end

      assign idx = pin_fidx[g*FN_W +: FN_W];
      assign val = fsel[g] ? fn_out[idx] : latch_r[g];
      assign want_drv = fsel[g] ? fn_oe[idx] : 1'b1;
      assign od = ~pin_output_style_select[g] |
                  (fsel[g] & ((idx == `FN_SMB_SDA) | (idx == `FN_SMB_SCL)));
      // analog pins keep their driver; parking them is software's job
      assign oe_nxt = crossbar_enable & want_drv & (od ? ~val : 1'b1);
      assign out_nxt = val & ~od;
      assign pu_nxt = dig[g] & ~oe_nxt & ~pullup_global_disable;
      assign rx_lvl[g] = dig[g] & pad_in[g];

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          out_r[g] <= 1'b0;
          oe_r[g] <= 1'b0;
          pu_r[g] <= 1'b1;
          drv_r[g] <= 1'b0;
          ana_r[g] <= 1'b0;
          lvl_r[g] <= 1'b1;
          lvl_prev_r[g] <= 1'b1;
          dig_prev_r[g] <= 1'b1;
          evt_r[g] <= 1'b0;
        end else begin
          out_r[g] <= out_nxt;
          oe_r[g] <= oe_nxt;
          pu_r[g] <= pu_nxt;
          drv_r[g] <= pin_drive_strength_select[g];
          ana_r[g] <= ~dig[g];
          lvl_r[g] <= rx_lvl[g];
          lvl_prev_r[g] <= lvl_r[g];
          dig_prev_r[g] <= dig[g];
          // kind checks are one cycle newer than the level samples, so a switch from analog to digital with the pad high raises an event
          evt_r[g] <= dig[g] & dig_prev_r[g] & (lvl_r[g] != lvl_prev_r[g]);
        end
      end
    end
  endgenerate

  assign pad_out = out_r;
  assign pad_oe = oe_r;
  assign pad_pullup_en = pu_r;
  assign pad_drive_high = drv_r;
  assign pad_analog = ana_r;
  assign port_rd_pins = lvl_r;
  assign pin_event = evt_r;

  // ==========================================================
  // inputs routed back to peripherals
  reg [N_FN-1:0] fn_in_nxt;
  reg [N_FN-1:0] fn_in_r;
  reg [N_XBAR-1:0] claimed_r;
  integer q;

  always @* begin
    fn_in_nxt = {N_FN{1'b0}};
    for (q = 0; q < N_XBAR; q = q + 1) begin
      if (asg_valid[q]) begin
        fn_in_nxt[asg_idx[q*FN_W +: FN_W]] = rx_lvl[q];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_in_r <= {N_FN{1'b0}};
      claimed_r <= {N_XBAR{1'b0}};
    end else begin
      fn_in_r <= fn_in_nxt;
      claimed_r <= asg_valid;
    end
  end

  assign fn_in = fn_in_r;
  assign pin_claimed = claimed_r;

endmodule // port_xbar

// ### verification/pad_model.sv
// outside world at the pads: resolves each pad level from the cell and an outside driver
`timescale 1ns/100ps
module pad_model (
  // clock
  input wire clk,
  // cell side
  input wire [15:0] pad_out,
  input wire [15:0] pad_oe,
  input wire [15:0] pad_pullup_en,
  // outside driver
  input wire [15:0] ext_en,
  input wire [15:0] ext_val,
  output logic [15:0] pad_in
);
  logic [15:0] float_r = 16'h0;
  // an undriven pad without pull-up wanders, so a stale level never passes for a real one
  always @(posedge clk) float_r <= ~float_r;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pullup_en | float_r));
endmodule // pad_model

// ### verification/port_xbar_assertions.sv
// assertions on the pin cell and crossbar ports
`timescale 1ns/100ps
module port_xbar_checks (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire [14:0] pin_input_kind_select,
  input wire pullup_global_disable,
  input wire crossbar_enable,
  input wire [7:0] function_select_0,
  input wire [7:0] function_select_2,
  // pads and status
  input wire [15:0] pad_in,
  input wire [15:0] port_rd_pins,
  input wire [14:0] pin_claimed,
  input wire [15:0] pin_event,
  input wire [15:0] pad_oe,
  input wire [15:0] pad_pullup_en,
  input wire [15:0] pad_analog
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  // a kind change may swallow the event, so the pin must stay digital throughout
  sequence s_flip;
    pin_input_kind_select[3] && $stable(pin_input_kind_select[3]) && $changed(pad_in[3])
      ##1 pin_input_kind_select[3];
  endsequence
  property p_evt; s_flip |=> pin_event[3]; endproperty
  property p_oe_off; !crossbar_enable |=> pad_oe == 16'h0; endproperty
  property p_pu_glob; pullup_global_disable |=> pad_pullup_en == 16'h0; endproperty
  property p_pu_oe; (pad_pullup_en & pad_oe) == 16'h0; endproperty
  property p_analog;
    1 |=> pad_analog[14:0] == ~$past(pin_input_kind_select)
      && (pad_pullup_en[14:0] & pad_analog[14:0]) == 15'h0;
  endproperty
  property p_rd;
    1 |=> port_rd_pins == ($past(pad_in) & {1'b1, $past(pin_input_kind_select)});
  endproperty
  property p_uart; function_select_0[0] |=> pin_claimed[5:4] == 2'h3; endproperty
  property p_second_serial_periph; function_select_2[0] |=> pin_claimed[11:8] == 4'hf; endproperty
  a_evt: assert property (p_evt) else $error("no event pulse");
  a_oe_off: assert property (p_oe_off) else $error("driver on while disabled");
  a_pu_glob: assert property (p_pu_glob) else $error("pull-up not disabled");
  a_pu_oe: assert property (p_pu_oe) else $error("pull-up on driven pad");
  a_analog: assert property (p_analog) else $error("analog cell wrong");
  a_rd: assert property (p_rd) else $error("pin read wrong");
  a_uart: assert property (p_uart) else $error("uart pins not claimed");
  a_second_serial_periph: assert property (p_second_serial_periph) else $error("second_serial_periph pins not claimed");
endmodule // port_xbar_checks

// ### verification/tb_top.sv
// self-checking testbench for the pin cells and priority crossbar
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, pullup_global_disable, crossbar_enable;
  logic [14:0] pin_input_kind_select, crossbar_bypass_bits, pin_claimed;
  logic [15:0] pin_output_style_select, pin_drive_strength_select, port_wr_mask;
  logic [15:0] port_wr_data, port_rd_pins, port_rd_latch, pin_event, pad_in, pad_out;
  logic [15:0] pad_oe, pad_pullup_en, pad_drive_high, pad_analog, ext_en, ext_val;
  logic [7:0] function_select_0, function_select_1, function_select_2;
  logic [1:0] slave_select_mode_bits;
  logic [25:0] fn_out, fn_oe, fn_in;
  int mismatches, num_checks;
  port_xbar port_xbar_i (.*);
  pad_model pad_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] m, input logic [15:0] d);
    @(posedge clk);
    port_wr_mask <= m;
    port_wr_data <= d;
    @(posedge clk);
    port_wr_mask <= 16'h0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_gpio;
    wr(16'h8000, 16'h0000);
    step(2);
    chk("oe while disabled", 16'h0, pad_oe);
    @(posedge clk);
    crossbar_enable <= 1'b1;
    pin_output_style_select <= 16'h8000;
    pin_drive_strength_select <= 16'h8000;
    step(2);
    chk("pp low", 16'h8, {pad_oe[15], pad_out[15], pad_pullup_en[15], port_rd_pins[15]});
    chk("drive", 16'h8000, pad_drive_high);
    wr(16'h8000, 16'h8000);
    step(2);
    chk("pp high", 16'hd, {pad_oe[15], pad_out[15], pad_pullup_en[15], port_rd_pins[15]});
    chk("latch", 16'hffff, port_rd_latch);
    @(posedge clk);
    pin_output_style_select <= 16'h0;
    ext_en <= 16'h8000;
    step(2);
    chk("od rel", 16'h2, {pad_oe[15], pad_out[15], pad_pullup_en[15], port_rd_pins[15]});
    @(posedge clk);
    pullup_global_disable <= 1'b1;
    step(2);
    chk("pu off", 16'h0, pad_pullup_en);
    @(posedge clk);
    pullup_global_disable <= 1'b0;
    ext_en <= 16'h0;
    $display("test gpio done");
  endtask
  task automatic t_analog;
    @(posedge clk);
    pin_input_kind_select <= 15'h7ff0;
    crossbar_bypass_bits <= 15'h000f;
    ext_en <= 16'h000f;
    ext_val <= 16'h000f;
    step(2);
    chk("analog rd", 16'h0, port_rd_pins & 16'h000f);
    chk("analog pu", 16'h0, pad_pullup_en & 16'h000f);
    chk("analog cell", 16'h000f, pad_analog & 16'h000f);
    @(posedge clk);
    pin_input_kind_select <= 15'h7fff;
    step(2);
    chk("digital rd", 16'h000f, port_rd_pins & 16'h000f);
    @(posedge clk);
    ext_en <= 16'h0;
    crossbar_bypass_bits <= 15'h0;
    $display("test analog done");
  endtask
  task automatic t_xbar;
    @(posedge clk);
    function_select_0 <= 8'h03;
    fn_oe <= 26'h1;
    pin_output_style_select <= 16'h0010;
    ext_en <= 16'h0020;
    ext_val <= 16'h0020;
    step(2);
    chk("3-wire", 16'h0037, pin_claimed);
    chk("uart tx", 16'h2, {pad_oe[4], pad_out[4]});
    chk("uart rx", 16'h1, fn_in[1]);
    @(posedge clk);
    slave_select_mode_bits <= 2'h1;
    step(2);
    chk("4-wire", 16'h003f, pin_claimed);
    @(posedge clk);
    crossbar_bypass_bits <= 15'h0001;
    function_select_2 <= 8'h01;
    step(2);
    chk("skip", 16'h0f7e, pin_claimed);
    @(posedge clk);
    crossbar_bypass_bits <= 15'h0;
    function_select_0 <= 8'h04;
    function_select_2 <= 8'h0;
    ext_en <= 16'h0;
    pin_output_style_select <= 16'hffff;
    fn_oe <= 26'h400;
    fn_out <= 26'h400;
    step(2);
    chk("sda released", 16'h0, pad_oe[0]);
    @(posedge clk);
    fn_out <= 26'h0;
    step(2);
    chk("sda low", 16'h2, {pad_oe[0], pad_out[0]});
    @(posedge clk);
    function_select_0 <= 8'h0;
    fn_oe <= 26'h0;
    pin_output_style_select <= 16'h0;
    ext_val <= 16'h0;
    $display("test crossbar done");
  endtask
  task automatic t_evt;
    @(posedge clk);
    ext_en <= 16'h0008;
    crossbar_bypass_bits <= 15'h0008;
    ext_val <= 16'h0;
    step(2);
    chk("event", 16'h1, pin_event[3]);
    step(1);
    chk("event end", 16'h0, pin_event[3]);
    @(posedge clk);
    pin_input_kind_select <= 15'h7ff7;
    step(3);
    @(posedge clk);
    ext_val <= 16'h0008;
    step(2);
    chk("analog event", 16'h0, pin_event[3]);
    $display("test event done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {pullup_global_disable, crossbar_enable, slave_select_mode_bits} = 4'h0;
    pin_input_kind_select = 15'h7fff;
    crossbar_bypass_bits = 15'h0;
    {pin_output_style_select, pin_drive_strength_select} = 32'h0;
    {port_wr_mask, port_wr_data, ext_en, ext_val} = 64'h0;
    {function_select_0, function_select_1, function_select_2} = 24'h0;
    {fn_out, fn_oe} = 52'h0;
    step(5);
    chk("reset oe", 16'h0, pad_oe);
    chk("reset pu", 16'hffff, pad_pullup_en);
    chk("reset analog", 16'h0, pad_analog);
    chk("reset drive", 16'h0, pad_drive_high);
    @(posedge clk);
    rst_n <= 1'b1;
    t_gpio();
    t_analog();
    t_xbar();
    t_evt();
    print_verdict();
  end
  // a hang ends the run as a failure
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule // tb_top
bind port_xbar port_xbar_checks port_xbar_checks_i (.*);
